// ### tdc_config_register_bank.sv
// apb register bank holding the operating mode of a two-channel
// time-to-digital converter, and the decoded fields it drives out
// assumes an apb master on clk; rst is the power-up reset pin path
//
// What this block does
// - there are seven configuration registers of 32 bits that set the operating mode.
// - the upper 24 bits of each register are written settings; only register 1's top byte (link check) and register 3's bit 30 (status word) read back.
// - the low 8 bits of each register are a free identifier that reads back.
// - a read of address 5 returns the top byte of register 1 as a link check.
// - bit 30 of register 3 selects first-wave mode, giving the delay fields of 3 and 4 their other meaning.
// - bits 30 and 31 of register 3 add functions while every other bit keeps its older layout.
// - register 0 holds the fire count in bits 28-31 and 8-10 (default 2) and the calibration periods in 22-23.
// - register 0 sits at address 0 with its low byte as the identifier.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tdc_cfg_consts.svh"

module tdc_config_register_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [`CFG_W-1:0] pwdata,
  output logic pready,
  output logic [`CFG_W-1:0] prdata,
  output logic pslverr,
  output logic [`CFG_W-1:0] config_word_0,
  output logic [`CFG_W-1:0] config_word_1,
  output logic [`CFG_W-1:0] config_word_2,
  output logic [`CFG_W-1:0] config_word_3,
  output logic [`CFG_W-1:0] config_word_4,
  output logic [`CFG_W-1:0] config_word_5,
  output logic [`CFG_W-1:0] config_word_6,
  output logic [6:0] fire_pulse_count,
  output logic [1:0] calibration_period_count,
  output logic first_wave_mode,
  output logic autocalc_enable,
  output logic [15:0] second_stop_delay,
  output logic [15:0] third_stop_delay,
  output logic soft_reset_busy
);

  // index of a register from a byte address
  function automatic tdc_cfg_pkg::reg_index_t index_of(input logic [`ADDR_W-1:0] a);
    return a[`ADDR_W-1:`IDX_LSB];
  endfunction : index_of

  // true for the seven configuration words
  function automatic logic is_cfg(input tdc_cfg_pkg::reg_index_t idx);
    return idx <= `IDX_CFG_LAST;
  endfunction : is_cfg

  // true for any register that answers without error
  function automatic logic is_mapped(input tdc_cfg_pkg::reg_index_t idx,
                                     input logic [`ADDR_W-1:0] a);
    logic aligned;
    aligned = (a[`ALIGN_MSB:0] == 2'h0);
    return aligned && (is_cfg(idx) || idx == `IDX_CMD || idx == `IDX_STATUS);
  endfunction : is_mapped

  // state held in this module
  tdc_cfg_pkg::cfg_bank_t words;
  tdc_cfg_pkg::cfg_word_t prdata_q;
  logic written_q;
  logic busy;

  // bus phase decode
  wire tdc_cfg_pkg::reg_index_t idx = index_of(paddr);
  wire mapped = is_mapped(idx, paddr);
  wire access = psel && penable;
  wire done = access && !busy; // completing edge of a transfer
  wire wr_done = done && pwrite && mapped;

  // writes split into configuration words and the reset command
  wire cfg_wr = wr_done && is_cfg(idx);
  wire cmd_wr = wr_done && (idx == `IDX_CMD);
  wire soft_reset = cmd_wr && (pwdata[`ID_MSB:`ID_LSB] == `SOFT_RESET_CODE);

  // the seven configuration words and their defaults
  cfg_word_store u_store (
    .clk(clk),
    .rst(rst),
    .clear(soft_reset),
    .wr_en(cfg_wr),
    .wr_index(idx),
    .wr_data(pwdata),
    .words(words)
  );

  // stalls the bus until the defaults have settled
  soft_reset_seq u_seq (
    .clk(clk),
    .rst(rst),
    .start(soft_reset),
    .busy(busy)
  );

  // word selection for outputs and readback
  wire tdc_cfg_pkg::cfg_word_t w0 = words[0*`CFG_W +: `CFG_W];
  wire tdc_cfg_pkg::cfg_word_t w1 = words[1*`CFG_W +: `CFG_W];
  wire tdc_cfg_pkg::cfg_word_t w2 = words[2*`CFG_W +: `CFG_W];
  wire tdc_cfg_pkg::cfg_word_t w3 = words[3*`CFG_W +: `CFG_W];
  wire tdc_cfg_pkg::cfg_word_t w4 = words[4*`CFG_W +: `CFG_W];
  wire tdc_cfg_pkg::cfg_word_t w5 = words[5*`CFG_W +: `CFG_W];
  wire tdc_cfg_pkg::cfg_word_t w6 = words[6*`CFG_W +: `CFG_W];
  wire tdc_cfg_pkg::cfg_word_t sel_word = words[idx*`CFG_W +: `CFG_W];

  // besides the status bits, only the identifier byte of a word and the top byte of word 1 may leave through the bus
  wire [`ID_MSB:`ID_LSB] id_byte = sel_word[`ID_MSB:`ID_LSB];
  wire [`TOP_MSB-`TOP_LSB:0] check_byte = w1[`TOP_MSB:`TOP_LSB];

  // status word: busy, first-wave active, written since reset
  wire tdc_cfg_pkg::cfg_word_t status_word = {
    29'h0000000,
    written_q,
    w3[`FIRST_WAVE_BIT],
    busy
  };

  // readback value; upper settings masked to zero except word 1's top byte at the link check and the status first-wave bit
  tdc_cfg_pkg::cfg_word_t rd_value;
  always_comb begin
    rd_value = `RD_ZERO;
    if (!mapped) begin
      rd_value = `RD_ZERO;
    end else if (idx == `IDX_CHECK) begin
      // link check byte low, own identifier in the next byte
      rd_value = {16'h0000, id_byte, check_byte};
    end else if (is_cfg(idx)) begin
      rd_value = {24'h000000, id_byte};
    end else if (idx == `IDX_STATUS) begin
      rd_value = status_word;
    end else begin
      rd_value = `RD_ZERO;
    end
  end

  // read data taken while selected, so it is stable in the access phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q <= `RD_ZERO;
    end else if (psel) begin
      prdata_q <= rd_value;
    end
  end

  // sticky marker of host configuration; only a reset clears it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      written_q <= 1'b0;
    end else if (cfg_wr) begin
      written_q <= 1'b1;
    end else if (soft_reset) begin
      written_q <= 1'b0;
    end
  end

  // handshake: no wait states except while a soft reset settles
  assign pready = access && !busy;
  assign pslverr = done && !mapped;
  assign prdata = prdata_q;
  assign soft_reset_busy = busy;

  // whole words to the converter core, straight from flops
  assign config_word_0 = w0;
  assign config_word_1 = w1;
  assign config_word_2 = w2;
  assign config_word_3 = w3;
  assign config_word_4 = w4;
  assign config_word_5 = w5;
  assign config_word_6 = w6;

  // fire count is split; high part at 8-10, low part at 28-31
  assign fire_pulse_count = {
    w0[`FIRE_HI_MSB:`FIRE_HI_LSB],
    w0[`FIRE_LO_MSB:`FIRE_LO_LSB]
  };
  assign calibration_period_count = w0[`CALPER_MSB:`CALPER_LSB];

  // the two added functions of register 3
  assign first_wave_mode = w3[`FIRST_WAVE_BIT];
  assign autocalc_enable = w3[`AUTOCALC_BIT];

  // delay fields keep their bits; the core reads them per first_wave_mode
  assign second_stop_delay = w3[`DELAY_MSB:`DELAY_LSB];
  assign third_stop_delay = w4[`DELAY_MSB:`DELAY_LSB];

endmodule : tdc_config_register_bank
`default_nettype wire

// ### tdc_cfg_consts.svh
// constants of the time-converter configuration register bank
// assumes a 32-bit apb bus at 100 mhz and word-aligned registers
`ifndef TDC_CFG_CONSTS_SVH
`define TDC_CFG_CONSTS_SVH

// geometry
`define CFG_COUNT 7
`define CFG_W 32
`define ADDR_W 8
`define IDX_W 6
`define IDX_LSB 2
`define ALIGN_MSB 1

// register indices, byte address is four times the index
`define IDX_CFG0 6'h00
`define IDX_CFG_LAST 6'h06
`define IDX_CHECK_SRC 6'h01
`define IDX_CHECK 6'h05
`define IDX_CMD 6'h07
`define IDX_STATUS 6'h08

// field positions
`define ID_MSB 7
`define ID_LSB 0
`define TOP_MSB 31
`define TOP_LSB 24
`define FIRE_LO_MSB 31
`define FIRE_LO_LSB 28
`define FIRE_HI_MSB 10
`define FIRE_HI_LSB 8
`define CALPER_MSB 23
`define CALPER_LSB 22
`define FIRST_WAVE_BIT 30
`define AUTOCALC_BIT 31
`define DELAY_MSB 23
`define DELAY_LSB 8
`define STAT_BUSY_BIT 0
`define STAT_FW_BIT 1
`define STAT_WRITTEN_BIT 2

// reset values
`define RST_CFG0 32'h22066800
`define RST_CFG1 32'h55000000
`define RST_CFG2 32'h20000000
`define RST_CFG3 32'h18000000
`define RST_CFG4 32'h00000000
`define RST_CFG5 32'h00000000
`define RST_CFG6 32'h00000000
`define RD_ZERO 32'h00000000

// soft reset command and its hold time
`define SOFT_RESET_CODE 8'h50
`define CLK_PERIOD_NS 10
`define SOFT_RESET_NS 100
`define SOFT_RESET_CYCLES ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 8

`endif

// ### tdc_cfg_pkg.sv
// types shared by the configuration register bank files
// assumes tdc_cfg_consts.svh is available on the include path
`include "tdc_cfg_consts.svh"

package tdc_cfg_pkg;
  typedef logic [`CFG_W-1:0] cfg_word_t;
  typedef logic [`IDX_W-1:0] reg_index_t;
  typedef logic [`CFG_COUNT*`CFG_W-1:0] cfg_bank_t;
  typedef logic [`CNT_W-1:0] count_t;
  typedef enum logic [0:0] {seq_idle, seq_busy} seq_state_e;
endpackage : tdc_cfg_pkg

// ### cfg_word_store.sv
// storage for the seven configuration words with their defaults
// assumes writes come already decoded from the bus slave on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "tdc_cfg_consts.svh"

module cfg_word_store (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic wr_en,
  input wire tdc_cfg_pkg::reg_index_t wr_index,
  input wire tdc_cfg_pkg::cfg_word_t wr_data,
  output tdc_cfg_pkg::cfg_bank_t words
);

  // default per word, used by both resets
  function automatic tdc_cfg_pkg::cfg_word_t default_word(input int idx);
    tdc_cfg_pkg::cfg_word_t w;
    case (idx)
      0: w = `RST_CFG0;
      1: w = `RST_CFG1;
      2: w = `RST_CFG2;
      3: w = `RST_CFG3;
      4: w = `RST_CFG4;
      5: w = `RST_CFG5;
      default: w = `RST_CFG6;
    endcase
    return w;
  endfunction : default_word

  // one flop word per register; the soft clear wins over a write
  genvar gi;
  generate
    for (gi = 0; gi < `CFG_COUNT; gi = gi + 1) begin : g_word
      // elaboration-time constant, so the async reset branch loads a fixed value
      localparam tdc_cfg_pkg::cfg_word_t reset_word = default_word(gi);
      tdc_cfg_pkg::cfg_word_t word_q;
      wire hit = wr_en && (wr_index == tdc_cfg_pkg::reg_index_t'(gi));
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          word_q <= reset_word;
        end else if (clear) begin
          word_q <= reset_word;
        end else if (hit) begin
          word_q <= wr_data;
        end
      end
      assign words[gi*`CFG_W +: `CFG_W] = word_q;
    end
  endgenerate

endmodule : cfg_word_store
`default_nettype wire

// ### soft_reset_seq.sv
// holds the bank busy for a fixed time after a soft reset command
// assumes start is a one-cycle pulse on the bank clock
`timescale 1ns/1ps
`default_nettype none
`include "tdc_cfg_consts.svh"

module soft_reset_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  output logic busy
);

  tdc_cfg_pkg::seq_state_e state_q;
  tdc_cfg_pkg::seq_state_e state_d;
  tdc_cfg_pkg::count_t count_q;
  tdc_cfg_pkg::count_t count_d;
  wire tdc_cfg_pkg::count_t hold_cycles = tdc_cfg_pkg::count_t'(`SOFT_RESET_CYCLES);

  // count down the hold time, restart on a fresh command
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    case (state_q)
      tdc_cfg_pkg::seq_idle: begin
        if (start) begin
          state_d = tdc_cfg_pkg::seq_busy;
          count_d = hold_cycles;
        end
      end
      default: begin
        if (start) begin
          count_d = hold_cycles;
        end else if (count_q <= tdc_cfg_pkg::count_t'(1)) begin
          state_d = tdc_cfg_pkg::seq_idle;
          count_d = '0;
        end else begin
          count_d = count_q - tdc_cfg_pkg::count_t'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= tdc_cfg_pkg::seq_idle;
      count_q <= '0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  assign busy = (state_q == tdc_cfg_pkg::seq_busy);

endmodule : soft_reset_seq
`default_nettype wire

// ### tdc_cfg_properties.sv
// port checker for the configuration register bank
// assumes apb on clk, async active-high rst; bound below
`timescale 1ns/1ps
`default_nettype none
`include "tdc_cfg_consts.svh"
module tdc_cfg_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [`CFG_W-1:0] pwdata,
  input wire logic pready,
  input wire logic [`CFG_W-1:0] prdata,
  input wire logic pslverr,
  input wire logic [`CFG_W-1:0] config_word_0,
  input wire logic [`CFG_W-1:0] config_word_1,
  input wire logic [`CFG_W-1:0] config_word_3,
  input wire logic [6:0] fire_pulse_count,
  input wire logic first_wave_mode,
  input wire logic [15:0] second_stop_delay,
  input wire logic soft_reset_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // completed transfers, split by direction
  wire logic done = psel && penable && pready;
  wire logic rd_ok = done && !pwrite && !pslverr;
  wire logic wr_ok = done && pwrite && !pslverr;
  AST_FIRE_MAP: assert property (
    fire_pulse_count == {config_word_0[10:8], config_word_0[31:28]}) else $error("fire map");
  AST_MODE_MAP: assert property (
    first_wave_mode == config_word_3[30] && second_stop_delay == config_word_3[23:8])
    else $error("mode map");
  AST_WRITE_STORE: assert property (
    wr_ok && paddr == 8'h0c |=> config_word_3 == $past(pwdata)) else $error("store");
  AST_READ_HIDE: assert property (
    rd_ok && paddr <= 8'h18 && paddr != 8'h14 |-> prdata[31:8] == 24'h0) else $error("hide");
  AST_ID_READ: assert property (
    rd_ok && paddr == 8'h00 |-> prdata[7:0] == config_word_0[7:0]) else $error("id");
  AST_CHECK_READ: assert property (
    rd_ok && paddr == 8'h14 |-> prdata[7:0] == config_word_1[31:24]) else $error("check");
  AST_SOFT_CLEAR: assert property (
    wr_ok && paddr == 8'h1c && pwdata[7:0] == 8'h50 |-> ##[1:2] config_word_1 == `RST_CFG1)
    else $error("clear");
  AST_BUSY_STALL: assert property (
    soft_reset_busy |-> !pready) else $error("stall");
  AST_BUSY_LEN: assert property (
    $rose(soft_reset_busy) |-> soft_reset_busy[*8] ##[1:4] !soft_reset_busy) else $error("len");
  AST_MISALIGN: assert property (
    done && paddr[1:0] != 2'b00 |-> pslverr) else $error("misalign");
  // main scenarios reached
  COV_CHECK: cover property (rd_ok && paddr == 8'h14);
  COV_CLEAR: cover property ($rose(soft_reset_busy));
  COV_ERR: cover property (done && pslverr);
endmodule : tdc_cfg_checker
bind tdc_config_register_bank tdc_cfg_checker u_tdc_cfg_checker (.clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .config_word_0,
  .config_word_1, .config_word_3, .fire_pulse_count, .first_wave_mode, .second_stop_delay,
  .soft_reset_busy);
`default_nettype wire

// ### apb_host_model.sv
// apb master standing in for the host processor
// assumes xfer is called just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one idle edge first, so two calls never drive in one step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // released data is not left looking valid
  endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// ### tdc_config_register_bank_tb_top.sv
// self-checking bench for the configuration register bank
// assumes the bound checker and the apb host model
`timescale 1ns/1ps
`default_nettype none
`include "tdc_cfg_consts.svh"
module tdc_config_register_bank_tb_top;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, fw, ac, busy, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [31:0] cw [0:6];
  logic [6:0] fire;
  logic [1:0] cal;
  logic [15:0] dly2, dly3;
  int mismatches = 0;
  int tests_run = 0;
  localparam logic [31:0] DEF [0:6] = '{`RST_CFG0, `RST_CFG1, `RST_CFG2, `RST_CFG3,
    `RST_CFG4, `RST_CFG5, `RST_CFG6};
  apb_host_model u_apb_host_model (.clk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr);
  tdc_config_register_bank u_tdc_config_register_bank (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .config_word_0(cw[0]),
    .config_word_1(cw[1]), .config_word_2(cw[2]), .config_word_3(cw[3]),
    .config_word_4(cw[4]), .config_word_5(cw[5]), .config_word_6(cw[6]),
    .fire_pulse_count(fire), .calibration_period_count(cal), .first_wave_mode(fw),
    .autocalc_enable(ac), .second_stop_delay(dly2), .third_stop_delay(dly3),
    .soft_reset_busy(busy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_apb_host_model.xfer(1'b1, a, d, r, e);
    @(negedge clk); // stored words settle after the completing edge
  endtask : wr
  task automatic rd(input logic [7:0] a);
    u_apb_host_model.xfer(1'b0, a, 32'h0, r, e);
  endtask : rd
  task automatic check_defaults;
    for (int i = 0; i < 7; i++) chk(cw[i], DEF[i]);
    chk({25'h0, fire}, 32'h2);
  endtask : check_defaults
  task automatic write_readback;
    logic [31:0] d;
    for (int i = 0; i < 7; i++) begin
      d = {8'ha0 + i[7:0], 16'h1234, 8'h10 + i[7:0]};
      wr(8'(i * 4), d);
      chk(cw[i], d);
      rd(8'(i * 4));
      chk(r, (i == 5) ? 32'h000015a1 : {24'h0, 8'h10 + i[7:0]});
    end
  endtask : write_readback
  task automatic link_check;
    wr(8'h04, 32'hc3000000);
    rd(8'h14);
    chk(r, 32'h000015c3);
  endtask : link_check
  task automatic first_wave;
    wr(8'h0c, 32'hc0beef07);
    chk({30'h0, ac, fw}, 32'h3);
    chk({16'h0, dly2}, 32'hbeef);
    wr(8'h10, 32'h00123400);
    chk({16'h0, dly3}, 32'h1234);
    rd(8'h20);
    chk({29'h0, r[2:0]}, 32'h6);
  endtask : first_wave
  task automatic fire_field;
    wr(8'h00, 32'hb0c00500);
    chk({25'h0, fire}, 32'h5b);
    chk({30'h0, cal}, 32'h3);
    rd(8'h00);
    chk(r, 32'h0);
  endtask : fire_field
  task automatic refusals;
    rd(8'h24);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    wr(8'h06, 32'hffffffff);
    chk({31'h0, e}, 32'h1);
    chk(cw[1], 32'hc3000000);
  endtask : refusals
  task automatic soft_reset;
    wr(8'h1c, 32'h00000050);
    chk({31'h0, busy}, 32'h1);
    check_defaults();
    // this read is stalled by the hold and must see the cleared words
    rd(8'h14);
    chk(r, 32'h00000055);
    chk({31'h0, busy}, 32'h0);
    rd(8'h20);
    chk({29'h0, r[2:0]}, 32'h0);
  endtask : soft_reset
  task automatic complete_run;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // host holds the pin reset before any access
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    check_defaults();
    write_readback();
    link_check();
    first_wave();
    fire_field();
    refusals();
    soft_reset();
    complete_run();
  end
  // cut a hang short, generous against about 100 cycles of traffic
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule : tdc_config_register_bank_tb_top
`default_nettype wire
